//--- host_model.sv
// Host board serial master for the diagnostic status byte
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    import optic_ctl_pkg::*;
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Six clocks per level keeps well clear of the four-clock minimum
    task automatic wt();
        repeat (6) @(posedge clk_i);
    endtask
    // Start condition when s is high, stop when low
    task automatic cond(input logic s);
        sda_oe_o <= !s;
        wt();
        scl_o <= 1'b1;
        wt();
        sda_oe_o <= s;
        wt();
        scl_o <= !s;
        wt();
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_oe_o <= !b;
        wt();
        scl_o <= 1'b1;
        wt();
        r = sda_i;
        scl_o <= 1'b0;
        wt();
    endtask
    task automatic xbyte(input logic [7:0] v, input logic last, output logic [7:0] r,
                         output logic ack);
        for (int i = 7; i >= 0; i--) begin
            xbit(v[i], r[i]);
        end
        xbit(last, ack);
    endtask
    // Sets the pointer to the status byte, then writes wd or reads one byte with a NACK
    task automatic xfer(input logic [7:0] adr, input logic wr, input logic [7:0] wd,
                        output logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic a0, a1, a2, a3;
        cond(1'b1);
        xbyte(adr, 1'b1, r, a0);
        xbyte(STATUS_BYTE_IDX, 1'b1, r, a1);
        if (wr) begin
            xbyte(wd, 1'b1, d, a2);
        end else begin
            cond(1'b1);
            xbyte(adr | 8'h01, 1'b1, r, a2);
            xbyte(8'hFF, 1'b1, d, a3);
        end
        cond(1'b0);
        nak = a0 | a1 | a2;
    endtask
endmodule
`default_nettype wire

//--- optic_ctl_asserts.sv
// Pin-level checks for the transceiver control block
`timescale 1ns/100ps
`default_nettype none
module optic_ctl_asserts (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tx_off_i,
    input wire logic tx_off_open_i,
    input wire logic laser_trip_i,
    input wire logic eye_unsafe_i,
    input wire logic sig_lost_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic laser_en_o,
    input wire logic tx_fault_o,
    input wire logic tx_fault_oe_o,
    input wire logic rx_signal_lost_o,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Four samples cover the two sync flops plus the output register
    laser_off_a: assert property ((tx_off_i || tx_off_open_i) [*4] |-> !laser_en_o)
        else $error("laser on under tx-off");
    laser_on_a: assert property
        ((!tx_off_i && !tx_off_open_i && tx_fault_oe_o) [*4] |-> laser_en_o)
        else $error("laser off without cause");
    laser_trip_a: assert property (laser_trip_i [*4] |-> !laser_en_o && !tx_fault_oe_o)
        else $error("trip not handled");
    eye_unsafe_a: assert property (eye_unsafe_i [*4] |-> !laser_en_o && !tx_fault_oe_o)
        else $error("unsafe power not handled");
    fault_set_a: assert property ($fell(tx_fault_oe_o) |-> $past(laser_trip_i || eye_unsafe_i, 3))
        else $error("fault without trip");
    fault_clr_a: assert property ($rose(tx_fault_oe_o) |-> $past(tx_off_i || tx_off_open_i, 4))
        else $error("fault cleared without tx-off cycle");
    lost_hi_a: assert property (sig_lost_i [*4] |-> rx_signal_lost_o)
        else $error("signal-lost not raised");
    lost_lo_a: assert property (!sig_lost_i [*4] |-> !rx_signal_lost_o)
        else $error("signal-lost not cleared");
    drain_low_a: assert property (!tx_fault_o && !sda_o)
        else $error("open-drain data not low");
endmodule
bind optical_tx_fault_los_control optic_ctl_asserts checker_inst (
    .clk_i, .rst_n_i, .tx_off_i, .tx_off_open_i, .laser_trip_i, .eye_unsafe_i, .sig_lost_i,
    .scl_i, .sda_i, .laser_en_o, .tx_fault_o, .tx_fault_oe_o, .rx_signal_lost_o, .sda_o, .sda_oe_o
);
`default_nettype wire

//--- optic_ctl_pkg.sv
// Shared constants and carrier types for the transceiver control block
package optic_ctl_pkg;

    localparam logic [6:0] DIAG_DEV_ADDR7 = 7'h51;
    localparam logic [7:0] STATUS_BYTE_IDX = 8'h6E;
    localparam int STAT_TX_OFF_BIT = 7;
    localparam int STAT_FAULT_BIT = 2;
    localparam int STAT_LOST_BIT = 1;
    localparam int DIAG_BYTES = 256;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int SYNC_W = 7;

    // Host-side spacing between tx-off assertions; the device does not enforce it
    localparam int TX_OFF_GAP_MS = 10;
    localparam int CLK_KHZ = 125000;
    localparam int TX_OFF_GAP_CYC = TX_OFF_GAP_MS * CLK_KHZ;

    typedef struct packed {
        logic tx_off;
        logic tx_off_open;
        logic laser_trip;
        logic eye_unsafe;
        logic sig_lost;
        logic scl;
        logic sda;
    } pin_sync_t;

    // Synchroniser reset levels: tx-off asserted keeps the laser dark until real pin
    // levels arrive, and the serial lines rest at their pulled-up idle level
    localparam pin_sync_t PIN_SYNC_RST = '{tx_off: 1'b1, tx_off_open: 1'b1, laser_trip: 1'b0,
                                           eye_unsafe: 1'b0, sig_lost: 1'b1, scl: 1'b1,
                                           sda: 1'b1};

    typedef enum logic [2:0] {
        SER_IDLE,
        SER_RX,
        SER_ACK,
        SER_TX,
        SER_MACK
    } ser_state_t;

endpackage

//--- optical_tx_fault_los_control.sv
// Transmit disable, latched laser fault, signal-lost and diagnostic serial status
`timescale 1ns/100ps
`default_nettype none
module optical_tx_fault_los_control (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tx_off_i,
    input wire logic tx_off_open_i,
    input wire logic laser_trip_i,
    input wire logic eye_unsafe_i,
    input wire logic sig_lost_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic laser_en_o,
    output logic tx_fault_o,
    output logic tx_fault_oe_o,
    output logic rx_signal_lost_o,
    output logic sda_o,
    output logic sda_oe_o
);
    import optic_ctl_pkg::*;

    typedef struct packed {
        logic tx_off_prev;
        logic fault;
        logic laser_en;
        logic fault_oe;
        logic lost;
        logic scl_prev;
        logic sda_prev;
        ser_state_t st;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic full;
        logic got_addr;
        logic got_ptr;
        logic rw;
        logic [7:0] ptr;
        logic [7:0] tx;
        logic sda_oe;
        logic mack;
    } state_t;

    pin_sync_t pins_async;
    pin_sync_t pins;
    state_t s_q;
    state_t s_d;
    logic [7:0] diag_mem [DIAG_BYTES];
    logic [7:0] status_byte;
    logic [7:0] rd_byte;
    logic mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic tx_off_eff;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign pins_async = '{tx_off: tx_off_i, tx_off_open: tx_off_open_i,
                          laser_trip: laser_trip_i, eye_unsafe: eye_unsafe_i,
                          sig_lost: sig_lost_i, scl: scl_i, sda: sda_i};

    sync_2ff #(
        .W(SYNC_W),
        .RST_VAL(PIN_SYNC_RST)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pins_async),
        .sync_o(pins)
    );

    assign tx_off_eff = pins.tx_off | pins.tx_off_open;
    assign scl_rise = pins.scl & ~s_q.scl_prev;
    assign scl_fall = ~pins.scl & s_q.scl_prev;
    assign start_cond = pins.scl & s_q.scl_prev & s_q.sda_prev & ~pins.sda;
    assign stop_cond = pins.scl & s_q.scl_prev & ~s_q.sda_prev & pins.sda;

    // Status comes from the output flops so a read matches the pins
    always_comb begin
        status_byte = 8'h00;
        status_byte[STAT_TX_OFF_BIT] = s_q.tx_off_prev;
        status_byte[STAT_FAULT_BIT] = s_q.fault;
        status_byte[STAT_LOST_BIT] = s_q.lost;
    end

    assign rd_byte = (s_q.ptr == STATUS_BYTE_IDX) ? status_byte : diag_mem[s_q.ptr];

    always_comb begin
        s_d = s_q;
        mem_we = 1'b0;
        mem_wa = s_q.ptr;
        mem_wd = s_q.sh;

        s_d.tx_off_prev = tx_off_eff;
        // Trip sources set the latch; a trip present during the release wins
        if (pins.laser_trip || pins.eye_unsafe) begin
            s_d.fault = 1'b1;
        end else if (s_q.tx_off_prev && !tx_off_eff) begin
            s_d.fault = 1'b0;
        end
        // Laser only on with tx-off low, no latched fault and no live trip
        s_d.laser_en = !tx_off_eff && !s_d.fault;
        s_d.fault_oe = !s_d.fault;
        s_d.lost = pins.sig_lost;

        s_d.scl_prev = pins.scl;
        s_d.sda_prev = pins.sda;

        if (stop_cond) begin
            s_d.st = SER_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (start_cond) begin
            // Pointer survives a repeated start so reads follow a pointer write
            s_d.st = SER_RX;
            s_d.cnt = 3'h0;
            s_d.full = 1'b0;
            s_d.got_addr = 1'b0;
            s_d.got_ptr = 1'b0;
            s_d.sda_oe = 1'b0;
        end else begin
            unique case (s_q.st)
                SER_IDLE: begin
                    s_d.sda_oe = 1'b0;
                end
                SER_RX: begin
                    if (scl_rise && !s_q.full) begin
                        s_d.sh = {s_q.sh[6:0], pins.sda};
                        s_d.cnt = s_q.cnt + 3'h1;
                        s_d.full = (s_q.cnt == BIT_LAST);
                    end else if (scl_fall && s_q.full) begin
                        s_d.full = 1'b0;
                        if (!s_q.got_addr) begin
                            if (s_q.sh[7:1] == DIAG_DEV_ADDR7) begin
                                s_d.got_addr = 1'b1;
                                s_d.rw = s_q.sh[0];
                                s_d.st = SER_ACK;
                                s_d.sda_oe = 1'b1;
                            end else begin
                                s_d.st = SER_IDLE;
                            end
                        end else if (!s_q.got_ptr) begin
                            s_d.got_ptr = 1'b1;
                            s_d.ptr = s_q.sh;
                            s_d.st = SER_ACK;
                            s_d.sda_oe = 1'b1;
                        end else begin
                            // Status byte is read-only; a write there is acked and dropped
                            mem_we = (s_q.ptr != STATUS_BYTE_IDX);
                            s_d.ptr = s_q.ptr + 8'h01;
                            s_d.st = SER_ACK;
                            s_d.sda_oe = 1'b1;
                        end
                    end
                end
                SER_ACK: begin
                    if (scl_fall) begin
                        s_d.cnt = 3'h0;
                        if (s_q.rw) begin
                            s_d.st = SER_TX;
                            s_d.tx = rd_byte;
                            s_d.ptr = s_q.ptr + 8'h01;
                            s_d.sda_oe = ~rd_byte[7];
                        end else begin
                            s_d.st = SER_RX;
                            s_d.sda_oe = 1'b0;
                        end
                    end
                end
                SER_TX: begin
                    if (scl_fall) begin
                        if (s_q.cnt == BIT_LAST) begin
                            s_d.st = SER_MACK;
                            s_d.sda_oe = 1'b0;
                        end else begin
                            s_d.tx = {s_q.tx[6:0], 1'b0};
                            s_d.sda_oe = ~s_q.tx[6];
                            s_d.cnt = s_q.cnt + 3'h1;
                        end
                    end
                end
                SER_MACK: begin
                    if (scl_rise) begin
                        s_d.mack = ~pins.sda;
                    end else if (scl_fall) begin
                        if (s_q.mack) begin
                            s_d.st = SER_TX;
                            s_d.cnt = 3'h0;
                            s_d.tx = rd_byte;
                            s_d.ptr = s_q.ptr + 8'h01;
                            s_d.sda_oe = ~rd_byte[7];
                        end else begin
                            s_d.st = SER_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '{tx_off_prev: 1'b1, fault: 1'b0, laser_en: 1'b0, fault_oe: 1'b1,
                     lost: 1'b1, scl_prev: 1'b1, sda_prev: 1'b1, st: SER_IDLE,
                     cnt: 3'h0, sh: 8'h00, full: 1'b0, got_addr: 1'b0, got_ptr: 1'b0,
                     rw: 1'b0, ptr: 8'h00, tx: 8'h00, sda_oe: 1'b0, mack: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Plain storage for the rest of the diagnostic space; not reset, like an EEPROM shadow
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            diag_mem[mem_wa] <= mem_wd;
        end
    end

    assign laser_en_o = s_q.laser_en;
    assign tx_fault_o = 1'b0;
    assign tx_fault_oe_o = s_q.fault_oe;
    assign rx_signal_lost_o = s_q.lost;
    assign sda_o = 1'b0;
    assign sda_oe_o = s_q.sda_oe;
endmodule
`default_nettype wire

//--- sync_2ff.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
// Random pin stimulus with serial status reads against a reference model
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic toff, topen, trip, unsafe, lost, laser_en, fo, foe, rxl, so, soe, scl, hoe, sda;
    logic nak, t, fs, prev, fault;
    logic [7:0] d;
    logic [31:0] seed = 32'hA6BC;
    int n_mismatch = 0;
    int checks = 0;
    // Pull-up on the serial data line
    assign sda = !(hoe || soe);
    always #4 clk = !clk;
    optical_tx_fault_los_control DUT (
        .clk_i(clk), .rst_n_i(rst_n), .tx_off_i(toff), .tx_off_open_i(topen),
        .laser_trip_i(trip), .eye_unsafe_i(unsafe), .sig_lost_i(lost), .scl_i(scl),
        .sda_i(sda), .laser_en_o(laser_en), .tx_fault_o(fo), .tx_fault_oe_o(foe),
        .rx_signal_lost_o(rxl), .sda_o(so), .sda_oe_o(soe)
    );
    host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(hoe));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        // Tx-off rests grounded when not exercised
        {toff, topen, trip, unsafe, lost} = 5'h00;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        host.xfer(8'hA0, 1'b0, 8'h00, d, nak);
        chk({7'h00, nak}, 8'h01, "foreign address acked");
        host.xfer(8'hA2, 1'b1, 8'hFF, d, nak);
        chk({7'h00, nak}, 8'h00, "status write refused");
        $display("address test done");
        prev = 1'b0;
        fault = 1'b0;
        // Tx-off pulses are far shorter than the host spacing; the block may not rely on it
        for (int k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            t = seed[0] || (&seed[6:5]);
            fs = (&seed[9:7]) || (&seed[12:10]);
            toff <= seed[0];
            topen <= &seed[6:5];
            trip <= &seed[9:7];
            unsafe <= &seed[12:10];
            lost <= seed[13];
            fault = fs || (fault && !(prev && !t));
            prev = t;
            repeat (6) @(posedge clk);
            chk({6'h00, laser_en, foe}, {6'h00, !t && !fault, !fault}, "pins");
            chk({7'h00, rxl}, {7'h00, seed[13]}, "signal-lost pin");
            chk({6'h00, fo, so}, 8'h00, "open-drain data");
            host.xfer(8'hA2, 1'b0, 8'h00, d, nak);
            chk(d, {t, 4'h0, fault, seed[13], 1'b0}, "status byte");
            chk({7'h00, nak}, 8'h00, "status read refused");
        end
        $display("random pin test done");
        {toff, topen, unsafe, lost} <= 4'h0;
        trip <= 1'b1;
        repeat (6) @(posedge clk);
        trip <= 1'b0;
        repeat (6) @(posedge clk);
        chk({7'h00, foe}, 8'h00, "fault not latched");
        rst_n <= 1'b0;
        @(posedge clk);
        chk({4'h0, laser_en, foe, rxl, soe}, 8'h06, "reset levels");
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk({6'h00, laser_en, foe}, 8'h03, "power cycle kept fault");
        $display("power cycle test done");
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("FAIL t=%0t run limit reached", $time);
        print_verdict();
    end
endmodule
`default_nettype wire
